// file: design/btmr_pkg.sv
// btmr_pkg: register map, field positions, reset values for the basic timer
// assumes a 32-bit apb slave with word-aligned registers
`default_nettype none

package btmr_pkg;

    // *****************************************************************
    // register offsets
    // *****************************************************************
    localparam logic [11:0] OFS_COUNT = 12'h000;
    localparam logic [11:0] OFS_PRELOAD = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
    localparam logic [11:0] OFS_CONTROL = 12'h010;

    // *****************************************************************
    // control register fields
    // *****************************************************************
    localparam int CTL_ENABLE = 0;
    localparam int CTL_COUNT_UP = 2;
    localparam int CTL_AUTO_RESTART = 3;
    localparam int CTL_SOFT_RESET = 4;
    localparam int CTL_START = 5;
    localparam int CTL_RELOAD = 6;
    localparam int CTL_HALT = 7;
    localparam int CTL_PRESCALE_LSB = 16;
    localparam int PRESCALE_WIDTH = 16;

    // status and enable bit position
    localparam int EVT_BIT = 0;

    // *****************************************************************
    // widths and reset values
    // *****************************************************************
    localparam int WIDE_COUNT = 32;
    localparam int NARROW_COUNT = 16;
    localparam logic [31:0] MASK_WIDE = 32'hffffffff;
    localparam logic [31:0] MASK_NARROW = 32'h0000ffff;
    localparam logic [31:0] RST_COUNT = 32'h00000000;
    localparam logic [31:0] RST_PRELOAD = 32'h00000000;
    localparam logic [15:0] RST_PRESCALE = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

endpackage : btmr_pkg

`default_nettype wire

// file: design/btmr_prescaler.sv
// btmr_prescaler: clock-enable divider, one tick every setting plus one clocks
// assumes a synchronous reset and a restart request from the timer core
`default_nettype none

module btmr_prescaler (
    input wire logic core_clk,
    input wire logic rst_any,
    input wire logic ce,
    input wire logic run,
    input wire logic restart,
    input wire logic [btmr_pkg::PRESCALE_WIDTH-1:0] divisor,
    output logic tick
);

    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed {
        logic [btmr_pkg::PRESCALE_WIDTH-1:0] cnt;
    } btmr_psc_state_t;

    btmr_psc_state_t state_reg;
    btmr_psc_state_t state_next;

    assign tick = run && !restart && (state_reg.cnt >= divisor);

    // divider count, held at zero while stopped or restarting
    always_comb begin
        state_next = state_reg;
        if (!run || restart || tick) begin
            state_next.cnt = '0;
        end else begin
            state_next.cnt = state_reg.cnt + 16'h0001;
        end
    end

    // register with reset priority over clock enable
    always_ff @(posedge core_clk) begin
        if (rst_any) begin
            state_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

endmodule : btmr_prescaler

`default_nettype wire

// file: design/btmr_timer.sv
// btmr_timer: 16 or 32 bit basic timer with prescaler, up/down, one-shot or restart
// assumes an apb master on core_clk and a power manager reading the sleep outputs
//
// How it works
// - system reset returns all registers and logic to defaults
// - control soft reset bit makes a self reset restoring all defaults
// - timer reset is the or of system reset and soft reset
// - limit sets event flag; interrupt output is flag and its enable
// - power manager may sleep the block only while start is clear
// - asleep when not enabled, not started, or halted
// - prescaler field sets time per counter lsb
// - counter increments or decrements as configured
// - one-shot stops at limit and holds event as level
// - continuous mode reloads from preload at limit, event one pulse
// - control writes reload, halt or start the counter
// - count register shows hardware count and takes firmware writes
// - read data latched whole so byte reads see consistent value
// - 16-bit instance: upper count and preload bits read zero
// - automatic restart loads counter from preload register
// - preload has the same implemented width as the counter
// - registers decode at fixed offsets from instance base
// - prescaler ticks every setting plus one clocks
// - start resets divider, clears events; one-shot limit clears start
// - reload keeps counting; no effect after one-shot completes
//
// Chosen here: the APB interface to the registers.
`default_nettype none

module btmr_timer #(
    parameter int COUNT_WIDTH = btmr_pkg::WIDE_COUNT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic timer_irq,
    output logic timer_reset_out,
    output logic sleep_allowed,
    output logic asleep
);

    // *****************************************************************
    // helpers
    // *****************************************************************

    // mask of implemented counter bits for this instance width
    localparam logic [31:0] CNT_MASK = (COUNT_WIDTH == btmr_pkg::NARROW_COUNT) ?
        btmr_pkg::MASK_NARROW : btmr_pkg::MASK_WIDE;

    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    // true when the address names any register
    function automatic logic reg_mapped(input logic [11:0] addr);
        reg_mapped = reg_hit(addr, btmr_pkg::OFS_COUNT) ||
            reg_hit(addr, btmr_pkg::OFS_PRELOAD) ||
            reg_hit(addr, btmr_pkg::OFS_STATUS) ||
            reg_hit(addr, btmr_pkg::OFS_IRQ_EN) ||
            reg_hit(addr, btmr_pkg::OFS_CONTROL);
    endfunction : reg_mapped

    // one counter step in the configured direction, kept to the instance width
    function automatic logic [31:0] count_step(input logic [31:0] value, input logic up);
        if (up) begin
            count_step = (value + 32'h00000001) & CNT_MASK;
        end else begin
            count_step = (value - 32'h00000001) & CNT_MASK;
        end
    endfunction : count_step

    // *****************************************************************
    // behaviour notes
    // *****************************************************************
    // counting
    //   one divider tick per prescale plus one clocks while enabled, started
    //   and not halted; the divider restarts from zero when a control write sets start from clear
    //   the first tick lands prescale plus one clocks after the start write
    //   a prescale change during a run may give one short or long tick
    //   the limit is checked on the tick after the counter arrives there,
    //   so a down count from n fires on tick n plus one
    // events
    //   one-shot: start clears and the event flag stays set until cleared
    //   restart: the counter takes the preload and the flag lasts one cycle
    //   a set wins over a write-one clear or a start write in the same cycle
    //   the interrupt follows the flag only while its enable is set
    // firmware writes
    //   a count write replaces that cycle's tick step; avoid it while running
    //   a reload acts only while start is set, so not in the start write
    //   reload and soft reset are strobes and read back as zero
    //   soft reset lasts one cycle and is cleared by the reset it causes
    // bus
    //   zero wait states; read data is captured whole in the setup cycle
    //   unmapped or unaligned addresses answer pslverr, read zero, no write
    //   with ce low the block is frozen except for reset, and bus transfers are lost
    // power
    //   sleep is allowed whenever start is clear
    //   asleep also covers a disabled or halted timer

    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed {
        logic [31:0] count_value;
        logic [31:0] restart_value;
        logic event_flag;
        logic event_enable;
        logic [btmr_pkg::PRESCALE_WIDTH-1:0] prescale;
        logic enable;
        logic count_up;
        logic auto_restart;
        logic soft_reset;
        logic start;
        logic halt;
        logic [31:0] rdata;
        // registered copies of the status outputs
        logic irq_out;
        logic sleep_ok;
        logic asleep_out;
    } btmr_state_t;

    btmr_state_t state_reg;
    btmr_state_t state_next;

    logic timer_rst;
    logic setup_rd;
    logic wr_fire;
    logic tick;
    logic running;
    logic start_rise;
    logic psc_restart;
    logic at_limit;
    logic [31:0] ctl_view;
    logic [31:0] limit_value;
    logic unmapped;

    // *****************************************************************
    // reset and bus handshake
    // *****************************************************************

    // combined timer reset from system and soft reset
    assign timer_rst = !rstn || state_reg.soft_reset;
    assign timer_reset_out = timer_rst;

    // address names no register of this block
    assign unmapped = !reg_mapped(paddr);

    // zero-wait slave: access phase always completes
    assign pready = psel && penable;
    assign pslverr = psel && penable && unmapped;
    assign setup_rd = psel && !penable && !pwrite;
    assign wr_fire = psel && penable && pwrite && !unmapped;
    assign prdata = state_reg.rdata;

    // *****************************************************************
    // status outputs
    // *****************************************************************

    // status outputs straight from their flip-flops
    assign timer_irq = state_reg.irq_out;
    assign sleep_allowed = state_reg.sleep_ok;
    assign asleep = state_reg.asleep_out;

    // counting runs only when enabled, started and not halted
    assign running = state_reg.enable && state_reg.start && !state_reg.halt;

    // start going from clear to set by a control write
    assign start_rise = wr_fire && reg_hit(paddr, btmr_pkg::OFS_CONTROL) &&
        pwdata[btmr_pkg::CTL_START] && !state_reg.start;

    assign psc_restart = start_rise;

    assign limit_value = state_reg.count_up ? CNT_MASK : btmr_pkg::RST_COUNT;
    assign at_limit = (state_reg.count_value == limit_value);

    // control register as read back; reload and soft reset read zero
    always_comb begin
        ctl_view = btmr_pkg::RD_ZERO;
        ctl_view[btmr_pkg::CTL_ENABLE] = state_reg.enable;
        ctl_view[btmr_pkg::CTL_COUNT_UP] = state_reg.count_up;
        ctl_view[btmr_pkg::CTL_AUTO_RESTART] = state_reg.auto_restart;
        ctl_view[btmr_pkg::CTL_START] = state_reg.start;
        ctl_view[btmr_pkg::CTL_HALT] = state_reg.halt;
        ctl_view[btmr_pkg::CTL_PRESCALE_LSB +: btmr_pkg::PRESCALE_WIDTH] = state_reg.prescale;
    end

    // *****************************************************************
    // prescaler
    // *****************************************************************

    btmr_prescaler u_prescaler (
        .core_clk(core_clk),
        .rst_any(timer_rst),
        .ce(ce),
        .run(running),
        .restart(psc_restart),
        .divisor(state_reg.prescale),
        .tick(tick)
    );

    // *****************************************************************
    // next state
    // *****************************************************************
    always_comb begin
        state_next = state_reg;
        // priority, lowest first: self-clearing bits, read capture, counting,
        // firmware writes, then the limit event; later steps override earlier
        // soft reset is a one-cycle strobe, cleared by the reset it causes
        state_next.soft_reset = 1'b0;

        // restart-mode event lasts one cycle only
        if (state_reg.auto_restart) begin
            state_next.event_flag = 1'b0;
        end

        // whole register captured in setup so a read is consistent
        if (setup_rd) begin
            state_next.rdata = btmr_pkg::RD_ZERO;
            if (reg_hit(paddr, btmr_pkg::OFS_COUNT)) begin
                state_next.rdata = state_reg.count_value & CNT_MASK;
            end else if (reg_hit(paddr, btmr_pkg::OFS_PRELOAD)) begin
                state_next.rdata = state_reg.restart_value & CNT_MASK;
            end else if (reg_hit(paddr, btmr_pkg::OFS_STATUS)) begin
                state_next.rdata[btmr_pkg::EVT_BIT] = state_reg.event_flag;
            end else if (reg_hit(paddr, btmr_pkg::OFS_IRQ_EN)) begin
                state_next.rdata[btmr_pkg::EVT_BIT] = state_reg.event_enable;
            end else if (reg_hit(paddr, btmr_pkg::OFS_CONTROL)) begin
                state_next.rdata = ctl_view;
            end
        end

        // count step on each divider tick
        if (tick) begin
            if (at_limit) begin
                if (state_reg.auto_restart) begin
                    state_next.count_value = state_reg.restart_value & CNT_MASK;
                end else begin
                    state_next.start = 1'b0;
                end
            end else begin
                state_next.count_value = count_step(state_reg.count_value, state_reg.count_up);
            end
        end

        // register writes take effect in the access phase
        if (wr_fire) begin
            if (reg_hit(paddr, btmr_pkg::OFS_COUNT)) begin
                state_next.count_value = pwdata & CNT_MASK;
            end
            if (reg_hit(paddr, btmr_pkg::OFS_PRELOAD)) begin
                state_next.restart_value = pwdata & CNT_MASK;
            end
            if (reg_hit(paddr, btmr_pkg::OFS_STATUS) && pwdata[btmr_pkg::EVT_BIT]) begin
                state_next.event_flag = 1'b0; // write one to clear
            end
            if (reg_hit(paddr, btmr_pkg::OFS_IRQ_EN)) begin
                state_next.event_enable = pwdata[btmr_pkg::EVT_BIT];
            end
            if (reg_hit(paddr, btmr_pkg::OFS_CONTROL)) begin
                state_next.enable = pwdata[btmr_pkg::CTL_ENABLE];
                state_next.count_up = pwdata[btmr_pkg::CTL_COUNT_UP];
                state_next.auto_restart = pwdata[btmr_pkg::CTL_AUTO_RESTART];
                state_next.prescale =
                    pwdata[btmr_pkg::CTL_PRESCALE_LSB +: btmr_pkg::PRESCALE_WIDTH];
                state_next.halt = pwdata[btmr_pkg::CTL_HALT];
                state_next.start = pwdata[btmr_pkg::CTL_START];
                state_next.soft_reset = pwdata[btmr_pkg::CTL_SOFT_RESET];
                if (start_rise) begin
                    state_next.event_flag = 1'b0;
                end
                // reload only while start is set
                if (pwdata[btmr_pkg::CTL_RELOAD] && state_reg.start) begin
                    state_next.count_value = state_reg.restart_value & CNT_MASK;
                end
            end
        end

        // limit event set last so it wins over a clear
        if (tick && at_limit) begin
            state_next.event_flag = 1'b1;
        end

        // status outputs follow the final next state, so they change with it
        // interrupt gated by enable
        state_next.irq_out = state_next.event_flag && state_next.event_enable;
        state_next.sleep_ok = !state_next.start;
        // asleep when disabled, stopped or halted
        state_next.asleep_out = !state_next.enable || !state_next.start || state_next.halt;
    end

    // *****************************************************************
    // state register
    // *****************************************************************

    // system or soft reset restores every default
    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            // counter and preload
            state_reg.count_value <= btmr_pkg::RST_COUNT;
            state_reg.restart_value <= btmr_pkg::RST_PRELOAD;
            // events
            state_reg.event_flag <= 1'b0;
            state_reg.event_enable <= 1'b0;
            // control fields
            state_reg.prescale <= btmr_pkg::RST_PRESCALE;
            state_reg.enable <= 1'b0;
            state_reg.count_up <= 1'b0;
            state_reg.auto_restart <= 1'b0;
            state_reg.soft_reset <= 1'b0;
            state_reg.start <= 1'b0;
            state_reg.halt <= 1'b0;
            // read data and status outputs of an idle timer
            state_reg.rdata <= btmr_pkg::RD_ZERO;
            state_reg.irq_out <= 1'b0;
            state_reg.sleep_ok <= 1'b1;
            state_reg.asleep_out <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

endmodule : btmr_timer

`default_nettype wire

// file: test/btmr_timer_chk.sv
// btmr_timer_chk: port-level assertions for the basic timer
// assumes it is bound into every btmr_timer instance
`default_nettype none
module btmr_timer_chk #(
    parameter int COUNT_WIDTH = btmr_pkg::WIDE_COUNT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_irq,
    input wire logic timer_reset_out,
    input wire logic sleep_allowed,
    input wire logic asleep
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***********************************
    // sequences and assertions
    // ***********************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_ctl_wr;
        psel && penable && pwrite && ce && paddr == btmr_pkg::OFS_CONTROL;
    endsequence
    sequence s_cleared;
        !timer_irq && sleep_allowed && asleep;
    endsequence
    a_ready_now: assert property (psel && penable |-> pready)
        else $error("pready missing in access phase");
    a_unmapped_err: assert property (psel && penable && paddr > btmr_pkg::OFS_CONTROL
        |-> pslverr && (pwrite || prdata == 32'h00000000)) else $error("unmapped not refused");
    a_upper_zero: assert property (psel && penable && !pwrite
        && paddr <= btmr_pkg::OFS_PRELOAD |-> COUNT_WIDTH == 32 || prdata[31:16] == 16'h0000)
        else $error("upper count bits not zero");
    a_sys_reset: assert property (disable iff (1'b0) !rstn |-> timer_reset_out)
        else $error("timer reset missing");
    a_reset_clears: assert property (disable iff (1'b0) !rstn |=> s_cleared)
        else $error("state not cleared by reset");
    a_soft_reset: assert property (s_ctl_wr ##0 pwdata[4] |=> timer_reset_out ##1 s_cleared)
        else $error("soft reset not applied");
    a_sleep_asleep: assert property (sleep_allowed |-> asleep)
        else $error("idle timer not asleep");
    a_start_clears: assert property (s_ctl_wr ##0 (pwdata[5] && !pwdata[4] && sleep_allowed)
        |=> !timer_irq && !sleep_allowed) else $error("start did not clear events");
    a_stop_write: assert property (s_ctl_wr ##0 !(pwdata[5] || pwdata[4])
        |=> sleep_allowed && asleep) else $error("start clear did not stop");
    a_irq_masked: assert property (psel && penable && pwrite && ce
        && paddr == btmr_pkg::OFS_IRQ_EN && !pwdata[0] |=> !timer_irq) else $error("irq not masked");
endmodule : btmr_timer_chk

bind btmr_timer btmr_timer_chk #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (.core_clk, .rstn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_irq, .timer_reset_out,
    .sleep_allowed, .asleep);
`default_nettype wire

// file: test/test_basic_timer_16_32.sv
// test_basic_timer_16_32: self-checking bench for a 16-bit timer instance
// assumes btmr_pkg, the design and the checker bind are compiled first
`default_nettype none
module test_basic_timer_16_32;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] re; logic err;} btmr_row_t;
    logic core_clk, rstn, ce, psel, penable, pwrite, pready, pslverr, rd_err;
    logic timer_irq, timer_reset_out, sleep_allowed, asleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    int num_errors = 0;
    int total_checks = 0;
    int pulses;
    // register rows: address, write value, read-back value, refused
    btmr_row_t rows [5] = '{'{btmr_pkg::OFS_COUNT, 32'h12345678, 32'h00005678, 1'b0},
        '{btmr_pkg::OFS_PRELOAD, 32'hffffabcd, 32'h0000abcd, 1'b0},
        '{btmr_pkg::OFS_IRQ_EN, 32'h00000001, 32'h00000001, 1'b0},
        '{btmr_pkg::OFS_CONTROL, 32'h00030085, 32'h00030085, 1'b0},
        '{12'h014, 32'h0000beef, 32'h00000000, 1'b1}};
    btmr_timer #(.COUNT_WIDTH(16)) dut (.core_clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .timer_irq, .timer_reset_out, .sleep_allowed, .asleep);
    // ***********************************
    // clock, bus tasks, checks
    // ***********************************
    always #20 core_clk = ~core_clk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
    // main sequence
    initial begin
        core_clk = 0; rstn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd_data);
        end
        $display("test reset values done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].wd);
            apb(1'b0, rows[i].a, 32'h0);
            chk("read back", rows[i].re, rd_data);
            chk("pslverr", {31'h0, rows[i].err}, {31'h0, rd_err});
        end
        $display("test register table done");
        apb(1'b1, btmr_pkg::OFS_COUNT, 32'h0);
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00030025);
        repeat (40) @(posedge core_clk);
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h000300a5);
        apb(1'b0, btmr_pkg::OFS_COUNT, 32'h0);
        chk("prescaled count", 32'h0000000a, rd_data);
        chk("sleep_allowed", 32'h0, {31'h0, sleep_allowed});
        chk("asleep halted", 32'h1, {31'h0, asleep});
        $display("test prescaler done");
        apb(1'b1, btmr_pkg::OFS_COUNT, 32'h3);
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00000021);
        repeat (10) @(posedge core_clk);
        chk("start cleared", 32'h1, {31'h0, sleep_allowed});
        chk("irq level", 32'h1, {31'h0, timer_irq});
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00000041);
        apb(1'b0, btmr_pkg::OFS_COUNT, 32'h0);
        chk("count stopped", 32'h0, rd_data);
        apb(1'b0, btmr_pkg::OFS_STATUS, 32'h0);
        chk("status level", 32'h1, rd_data);
        apb(1'b1, btmr_pkg::OFS_IRQ_EN, 32'h0);
        #1;
        chk("irq masked", 32'h0, {31'h0, timer_irq});
        apb(1'b1, btmr_pkg::OFS_IRQ_EN, 32'h1);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, timer_irq});
        apb(1'b1, btmr_pkg::OFS_STATUS, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, timer_irq});
        $display("test one-shot done");
        apb(1'b1, btmr_pkg::OFS_PRELOAD, 32'h0000fff0);
        apb(1'b1, btmr_pkg::OFS_COUNT, 32'h0000fffe);
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h0000002d);
        pulses = 0;
        repeat (64) begin
            @(posedge core_clk);
            #1;
            if (timer_irq === 1'b1) pulses++;
        end
        chk("event pulses", 32'd4, 32'(pulses));
        chk("still running", 32'h0, {31'h0, sleep_allowed});
        $display("test continuous done");
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00000010);
        apb(1'b0, btmr_pkg::OFS_PRELOAD, 32'h0);
        chk("preload after soft reset", 32'h0, rd_data);
        apb(1'b0, btmr_pkg::OFS_IRQ_EN, 32'h0);
        chk("enable after soft reset", 32'h0, rd_data);
        $display("test soft reset done");
        // clock enable freezes the count, then reload while running
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00000025);
        ce <= 1'b0;
        repeat (10) @(posedge core_clk);
        ce <= 1'b1;
        apb(1'b0, btmr_pkg::OFS_COUNT, 32'h0);
        chk("count frozen by ce", 32'h1, rd_data);
        apb(1'b1, btmr_pkg::OFS_PRELOAD, 32'h00000100);
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00000065);
        apb(1'b0, btmr_pkg::OFS_COUNT, 32'h0);
        chk("reload keeps counting", 32'h00000101, rd_data);
        chk("asleep running", 32'h0, {31'h0, asleep});
        $display("test clock enable and reload done");
        apb(1'b1, btmr_pkg::OFS_CONTROL, 32'h00ff0021);
        rstn <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("timer_reset_out", 32'h1, {31'h0, timer_reset_out});
        @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("stopped by reset", 32'h1, {31'h0, sleep_allowed});
        $display("test system reset done");
        final_report();
    end
endmodule : test_basic_timer_16_32
`default_nettype wire
